// *** hdl/acfg_defs.svh ***
`ifndef ACFG_DEFS_SVH
`define ACFG_DEFS_SVH
// Purpose: offsets, field positions, reset values and counts of the config group
// Assumes: 8-bit register words, byte addresses as printed
// Notes: frame sizes and buffer capacity are plain defaults

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define ACFG_ADDR_ACCEL_CONFIG 8'h40
`define ACFG_ADDR_SPAN 8'h41
`define ACFG_ADDR_RATE_DIV 8'h45
`define ACFG_ADDR_THR_LO 8'h46
`define ACFG_ADDR_THR_HI 8'h47
`define ACFG_ADDR_FIFO_OP 8'h48
`define ACFG_ADDR_FIFO_SRC 8'h49
`define ACFG_ADDR_PIN1 8'h53

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define ACFG_RST_FILTER 4'hA
`define ACFG_RST_RATE 4'h8
`define ACFG_RST_SPAN 2'h1
`define ACFG_RST_DEC_EXP 3'h0
`define ACFG_RST_THR 13'h0000
`define ACFG_RST_SCALE 15'h1770
`define ACFG_RST_SRC 7'h10

// ------------------------------------------------------------
// field codes and bit positions
// ------------------------------------------------------------
`define ACFG_FILT_FOUR 4'h8
`define ACFG_FILT_TWO 4'h9
`define ACFG_FILT_NORMAL 4'hA
`define ACFG_RATE_MIN 4'h5
`define ACFG_RATE_MAX 4'hC
`define ACFG_RDIV_FIXED_BIT 7
`define ACFG_OP_FIXED_BIT 1
`define ACFG_OP_MODE_BIT 0
`define ACFG_SRC_ACC_BIT 6
`define ACFG_SRC_B5_BIT 5
`define ACFG_SRC_FIXED_BIT 4
`define ACFG_SRC_P1_BIT 3
`define ACFG_SRC_P2_BIT 2
`define ACFG_PIN_IN_BIT 4
`define ACFG_PIN_OUT_BIT 3
`define ACFG_PIN_OD_BIT 2
`define ACFG_PIN_POL_BIT 1

// ------------------------------------------------------------
// buffer sizing and scale
// ------------------------------------------------------------
`define ACFG_FIFO_CAP 14'h0400
`define ACFG_ACC_FRAME_LEN 14'h0007
`define ACFG_EVT_FRAME_LEN 14'h0002
`define ACFG_BASE_MG 15'h0BB8

`endif

// *** hdl/acfg_pkg.sv ***
// Purpose: shared types of the accelerometer config group
// Assumes: constants live in acfg_defs.svh
// Notes: none
package acfg_pkg;

	// ------------------------------------------------------------
	// register access request
	// ------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} acfg_req_t;

	// two-signal pin drive
	typedef struct packed {
		logic o;
		logic oe;
	} acfg_pin_t;

	// kind of frame pushed into the buffer
	typedef enum logic [1:0] {
		ACFG_FR_ACC = 2'h1,
		ACFG_FR_EVT = 2'h2
	} acfg_frame_t;

endpackage : acfg_pkg

// *** hdl/acfg_pin_sync.sv ***
// Purpose: three-stage pin synchroniser with agreement filter and rise pulse
// Assumes: d is asynchronous to sys_clk
// Notes: stage one feeds only stage two
module acfg_pin_sync (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// pin side
	input wire logic d,
	// synchronised side
	output logic q,
	output logic rise
);

	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic q_r;
	logic rise_r;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// a change counts only when the last two stages agree
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			q_r <= 1'b0;
			rise_r <= 1'b0;
		end else begin
			rise_r <= (s2_r == s3_r) && s3_r && !q_r;
			if (s2_r == s3_r) begin
				q_r <= s3_r;
			end
		end
	end

	assign q = q_r;
	assign rise = rise_r;

endmodule : acfg_pin_sync

// *** hdl/acfg_regs.sv ***
// Purpose: accelerometer config, buffer setup and first-pin setup registers
// Assumes: serial port decoder delivers one access per cycle as acfg_req_t
// Notes: fill level is a byte count kept here; frame storage is elsewhere
//
// Overview of operation
// - filter field selects four-fold, two-fold, normal
// - rate field codes 5..C select 12.5-1600 Hz
// - span field selects 3, 6, 12, 24 g
// - milli-g scale is 3000 shifted by span
// - buffer rate divided by two power exponent
// - threshold split: low byte, then upper five
// - watermark high while level at least threshold
// - threshold and level both count bytes
// - 14-bit level changes per whole frame only
// - mode bit: zero stream, one stop-when-full
// - accel store enable gates sample frames
// - pin event enables record rising pin edges
// - input enable makes first pin an input
// - output enable lets first pin drive
// - drive type and polarity shape the output
`include "acfg_defs.svh"
module acfg_regs (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// register access
	input acfg_pkg::acfg_req_t req,
	output logic [7:0] rd_data,
	output logic rd_valid,
	// sampling datapath
	input wire logic sample_tick,
	output logic [3:0] filter_sel,
	output logic [3:0] rate_sel,
	output logic [1:0] span_sel,
	output logic [14:0] full_scale_mg,
	output logic cfg_invalid,
	// buffer side
	input wire logic frame_rd,
	input wire logic [3:0] frame_rd_len,
	input wire logic pin2_input_en,
	output logic frame_push,
	output acfg_pkg::acfg_frame_t frame_kind,
	output logic evict_oldest,
	output logic frame_dropped,
	output logic [13:0] fill_level,
	output logic watermark,
	// first pin and second pin
	input wire logic irq_one_src,
	input wire logic irq_pin_one_sense,
	input wire logic irq_pin_two_sense,
	output acfg_pkg::acfg_pin_t irq_pin_one
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [6:0] dec_mask(input logic [2:0] e);
		dec_mask = 7'(({7'h00, 1'b1} << e) - 8'h01);
	endfunction : dec_mask

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = req.wr && (a == b);
	endfunction : hit

	// ------------------------------------------------------------
	// configuration storage
	// ------------------------------------------------------------
	logic [3:0] filter_r;
	logic [3:0] rate_r;
	logic [1:0] span_r;
	logic rdiv_fixed_r;
	logic [2:0] dec_exp_r;
	logic [12:0] thr_r;
	logic op_fixed_r;
	logic stop_mode_r;
	logic [6:0] src_r;
	logic [4:1] pin1_r;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			filter_r <= `ACFG_RST_FILTER;
			rate_r <= `ACFG_RST_RATE;
		end else if (hit(req.addr, `ACFG_ADDR_ACCEL_CONFIG)) begin
			filter_r <= req.wdata[7:4];
			rate_r <= req.wdata[3:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			span_r <= `ACFG_RST_SPAN;
		end else if (hit(req.addr, `ACFG_ADDR_SPAN)) begin
			span_r <= req.wdata[1:0];
		end
	end

	// exponent field is read-only, so it holds its reset value
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdiv_fixed_r <= 1'b1;
			dec_exp_r <= `ACFG_RST_DEC_EXP;
		end else if (hit(req.addr, `ACFG_ADDR_RATE_DIV)) begin
			rdiv_fixed_r <= req.wdata[`ACFG_RDIV_FIXED_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			thr_r <= `ACFG_RST_THR;
		end else if (hit(req.addr, `ACFG_ADDR_THR_LO)) begin
			thr_r[7:0] <= req.wdata;
		end else if (hit(req.addr, `ACFG_ADDR_THR_HI)) begin
			thr_r[12:8] <= req.wdata[4:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			op_fixed_r <= 1'b1;
			stop_mode_r <= 1'b0;
		end else if (hit(req.addr, `ACFG_ADDR_FIFO_OP)) begin
			op_fixed_r <= req.wdata[`ACFG_OP_FIXED_BIT];
			stop_mode_r <= req.wdata[`ACFG_OP_MODE_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			src_r <= `ACFG_RST_SRC;
		end else if (hit(req.addr, `ACFG_ADDR_FIFO_SRC)) begin
			src_r <= {req.wdata[`ACFG_SRC_ACC_BIT], 1'b0, req.wdata[4:2], 2'h0};
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pin1_r <= 4'h0;
		end else if (hit(req.addr, `ACFG_ADDR_PIN1)) begin
			pin1_r <= req.wdata[4:1];
		end
	end

	// ------------------------------------------------------------
	// read back
	// ------------------------------------------------------------
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		unique case (req.addr)
			`ACFG_ADDR_ACCEL_CONFIG: rd_mux = {filter_r, rate_r};
			`ACFG_ADDR_SPAN: rd_mux = {6'h00, span_r};
			`ACFG_ADDR_RATE_DIV: rd_mux = {rdiv_fixed_r, dec_exp_r, 4'h0};
			`ACFG_ADDR_THR_LO: rd_mux = thr_r[7:0];
			`ACFG_ADDR_THR_HI: rd_mux = {3'h0, thr_r[12:8]};
			`ACFG_ADDR_FIFO_OP: rd_mux = {6'h00, op_fixed_r, stop_mode_r};
			`ACFG_ADDR_FIFO_SRC: rd_mux = {1'b0, src_r};
			`ACFG_ADDR_PIN1: rd_mux = {3'h0, pin1_r, 1'b0};
			default: rd_mux = 8'h00;
		endcase
	end

	// registered answer, one cycle after the request
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= req.rd;
			if (req.rd) begin
				rd_data <= rd_mux;
			end
		end
	end

	// ------------------------------------------------------------
	// datapath settings
	// ------------------------------------------------------------
	logic bad_filter;
	logic bad_rate;

	assign bad_filter = (filter_r != `ACFG_FILT_FOUR) && (filter_r != `ACFG_FILT_TWO)
		&& (filter_r != `ACFG_FILT_NORMAL);
	assign bad_rate = (rate_r < `ACFG_RATE_MIN) || (rate_r > `ACFG_RATE_MAX);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			filter_sel <= `ACFG_RST_FILTER;
			rate_sel <= `ACFG_RST_RATE;
			span_sel <= `ACFG_RST_SPAN;
			full_scale_mg <= `ACFG_RST_SCALE;
			cfg_invalid <= 1'b0;
		end else begin
			filter_sel <= filter_r;
			rate_sel <= rate_r;
			span_sel <= span_r;
			full_scale_mg <= 15'(`ACFG_BASE_MG << span_r);
			cfg_invalid <= bad_filter || bad_rate;
		end
	end

	// ------------------------------------------------------------
	// pin inputs and event capture
	// ------------------------------------------------------------
	logic p1_rise;
	logic p2_rise;
	logic evt_pend_r;
	logic [6:0] dec_cnt_r;
	logic dec_hit;
	logic acc_wr;
	logic evt_wr;

	acfg_pin_sync u_sync_one (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.d(irq_pin_one_sense),
		.q(),
		.rise(p1_rise)
	);

	acfg_pin_sync u_sync_two (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.d(irq_pin_two_sense),
		.q(),
		.rise(p2_rise)
	);

	// a pending event survives a coincident accel frame and goes next
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			evt_pend_r <= 1'b0;
		end else if ((p1_rise && src_r[`ACFG_SRC_P1_BIT] && pin1_r[`ACFG_PIN_IN_BIT])
			|| (p2_rise && src_r[`ACFG_SRC_P2_BIT] && pin2_input_en)) begin
			evt_pend_r <= 1'b1;
		end else if (evt_wr) begin
			evt_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dec_cnt_r <= 7'h00;
		end else if (sample_tick) begin
			dec_cnt_r <= dec_cnt_r + 7'h01;
		end
	end

	assign dec_hit = sample_tick && ((dec_cnt_r & dec_mask(dec_exp_r)) == 7'h00);
	assign acc_wr = dec_hit && src_r[`ACFG_SRC_ACC_BIT];
	assign evt_wr = evt_pend_r && !acc_wr;

	// ------------------------------------------------------------
	// fill level and watermark
	// ------------------------------------------------------------
	logic [13:0] level_r;
	logic [13:0] wr_len;
	logic [13:0] rd_len;
	logic [13:0] after_rd;
	logic wr_any;
	logic fits;
	logic [13:0] level_nxt;

	assign wr_any = acc_wr || evt_wr;
	assign wr_len = acc_wr ? `ACFG_ACC_FRAME_LEN : `ACFG_EVT_FRAME_LEN;
	assign rd_len = (frame_rd && ({10'h000, frame_rd_len} <= level_r)) ?
		{10'h000, frame_rd_len} : 14'h0000;
	assign after_rd = level_r - rd_len;
	assign fits = (after_rd + wr_len) <= `ACFG_FIFO_CAP;

	always_comb begin
		level_nxt = after_rd;
		if (wr_any && fits) begin
			level_nxt = after_rd + wr_len;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			level_r <= 14'h0000;
		end else begin
			level_r <= level_nxt;
		end
	end

	// full stream buffer trades the oldest frame for the new one
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			frame_push <= 1'b0;
			frame_kind <= acfg_pkg::ACFG_FR_ACC;
			evict_oldest <= 1'b0;
			frame_dropped <= 1'b0;
		end else begin
			frame_push <= wr_any && (fits || !stop_mode_r);
			evict_oldest <= wr_any && !fits && !stop_mode_r;
			frame_dropped <= wr_any && !fits && stop_mode_r;
			if (wr_any) begin
				frame_kind <= acc_wr ? acfg_pkg::ACFG_FR_ACC : acfg_pkg::ACFG_FR_EVT;
			end
		end
	end

	assign fill_level = level_r;
	assign watermark = level_r >= {1'b0, thr_r};

	// ------------------------------------------------------------
	// first pin drive
	// ------------------------------------------------------------
	logic pin_level;

	// open drain only pulls low; the pull-up gives the high level
	assign pin_level = pin1_r[`ACFG_PIN_POL_BIT] ? irq_one_src : !irq_one_src;
	assign irq_pin_one.o = pin_level;
	assign irq_pin_one.oe = pin1_r[`ACFG_PIN_OUT_BIT]
		&& (!pin1_r[`ACFG_PIN_OD_BIT] || !pin_level);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence thr_write_s;
		req.wr && req.addr == `ACFG_ADDR_THR_LO;
	endsequence

	wm_level_a: assert property (##1 watermark == (fill_level >= {1'b0, thr_r}))
		else $error("watermark does not follow level");
	thr_write_a: assert property (thr_write_s |=> thr_r[7:0] == $past(req.wdata))
		else $error("threshold low byte not stored");
	rd_answer_a: assert property (req.rd |=> rd_valid ##1 !rd_valid || $past(req.rd))
		else $error("read answer timing wrong");
	stop_drop_a: assert property (stop_mode_r && wr_any && !fits |=> frame_dropped && !frame_push)
		else $error("stop mode accepted frame when full");
	stream_evict_a: assert property (!stop_mode_r && wr_any && !fits |=> evict_oldest && frame_push)
		else $error("stream mode did not evict");
	level_frame_a: assert property (!wr_any && rd_len == 14'h0000 |=> $stable(level_r))
		else $error("level moved without a frame");
	acc_gate_a: assert property (sample_tick && !src_r[`ACFG_SRC_ACC_BIT] |-> !acc_wr)
		else $error("accel frame stored while disabled");
	pin_idle_a: assert property (!pin1_r[`ACFG_PIN_OUT_BIT] |-> !irq_pin_one.oe)
		else $error("first pin drives while disabled");
	scale_span_a: assert property (span_r == 2'h3 |=> full_scale_mg == 15'h5DC0)
		else $error("full scale wrong at top span");
	level_cap_a: assert property (level_r <= `ACFG_FIFO_CAP)
		else $error("level exceeds capacity");

endmodule : acfg_regs

// *** tb/acfg_host.sv ***
// Purpose: host model issuing single register accesses to the config group
// Assumes: one strobe cycle per access, changes just after a rising edge
// Notes: fixed-one bits are always written set, as a careful host would
module acfg_host (
	// clock
	input wire logic sys_clk,
	// register access
	output acfg_pkg::acfg_req_t req
);
	timeunit 1ns;
	timeprecision 1ns;
`include "acfg_defs.svh"

	initial begin
		req = '0;
	end

	// ------------------------------------------------------------
	// one access; strobe drops at the edge that takes it
	// ------------------------------------------------------------
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		case (a)
			`ACFG_ADDR_RATE_DIV: v[7] = 1'b1;
			`ACFG_ADDR_FIFO_OP: v[1] = 1'b1;
			`ACFG_ADDR_FIFO_SRC: v[4] = 1'b1;
			default: v = d;
		endcase
		@(posedge sys_clk);
		req <= '{wr: w, rd: !w, addr: a, wdata: v};
		@(posedge sys_clk);
		req <= '0;
	endtask : access

	// pin must be an input before its events are captured
	task automatic arm_pin1();
		access(1'b1, `ACFG_ADDR_PIN1, 8'h10);
		access(1'b1, `ACFG_ADDR_FIFO_SRC, 8'h08);
	endtask : arm_pin1
endmodule : acfg_host

// *** tb/accel_config_fifo_setup_regs_bench.sv ***
// Purpose: self-checking bench of the config group
// Assumes: read data compared from a queue of expected values
// Notes: a second reset in mid-run clears the buffer level for the full test
module accel_config_fifo_setup_regs_bench;
	timeunit 1ns;
	timeprecision 1ns;
`include "acfg_defs.svh"

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic sys_clk, rstn, rd_valid, sample_tick, cfg_invalid, frame_rd, pin2_input_en;
	logic frame_push, evict_oldest, frame_dropped, watermark;
	logic irq_one_src, irq_pin_one_sense, irq_pin_two_sense;
	logic [7:0] rd_data;
	logic [3:0] filter_sel, rate_sel, frame_rd_len;
	logic [1:0] span_sel;
	logic [14:0] full_scale_mg;
	logic [13:0] fill_level;
	acfg_pkg::acfg_req_t req;
	acfg_pkg::acfg_frame_t frame_kind;
	acfg_pkg::acfg_pin_t irq_pin_one;
	logic [7:0] exp_q[$];
	int errors = 0, checked = 0, drops = 0, evicts = 0, cycles = 0;
	integer seed = 32'hd7c0;
	// generous: the whole run needs about 600 cycles
	localparam int LIMIT = 20000;

	acfg_host i_host (.sys_clk(sys_clk), .req(req));
	acfg_regs i_dut (.sys_clk(sys_clk), .rstn(rstn), .req(req), .rd_data(rd_data),
		.rd_valid(rd_valid), .sample_tick(sample_tick), .filter_sel(filter_sel),
		.rate_sel(rate_sel), .span_sel(span_sel), .full_scale_mg(full_scale_mg),
		.cfg_invalid(cfg_invalid), .frame_rd(frame_rd), .frame_rd_len(frame_rd_len),
		.pin2_input_en(pin2_input_en), .frame_push(frame_push), .frame_kind(frame_kind),
		.evict_oldest(evict_oldest), .frame_dropped(frame_dropped),
		.fill_level(fill_level), .watermark(watermark), .irq_one_src(irq_one_src),
		.irq_pin_one_sense(irq_pin_one_sense), .irq_pin_two_sense(irq_pin_two_sense),
		.irq_pin_one(irq_pin_one));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_host.access(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_host.access(1'b0, a, 8'h00);
	endtask : rd

	task automatic do_reset();
		rstn <= 1'b0;
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
	endtask : do_reset

	task automatic tick();
		@(posedge sys_clk);
		sample_tick <= 1'b1;
		@(posedge sys_clk);
		sample_tick <= 1'b0;
	endtask : tick

	task automatic wait_push(input logic [1:0] k, input logic [13:0] lvl);
		int n;
		n = 0;
		#1;
		while (frame_push !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk(frame_push, 1);
		chk(frame_kind, k);
		chk(fill_level, lvl);
	endtask : wait_push

	task automatic read_frame(input logic [13:0] lvl);
		@(posedge sys_clk);
		frame_rd <= 1'b1;
		frame_rd_len <= 4'h7;
		@(posedge sys_clk);
		frame_rd <= 1'b0;
		#1;
		chk(fill_level, lvl);
	endtask : read_frame

	// read data monitor, counters and hang guard
	always @(posedge sys_clk) begin
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0) chk(32'hDEAD, 32'h0);
			else chk(rd_data, exp_q.pop_front());
		end
		if (frame_dropped === 1'b1) drops++;
		if (evict_oldest === 1'b1) evicts++;
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			conclude();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [7:0] v;
		logic [31:0] rnd;
		logic o_x;
		rstn = 1'b0;
		sample_tick = 1'b0;
		frame_rd = 1'b0;
		frame_rd_len = 4'h0;
		pin2_input_en = 1'b0;
		irq_one_src = 1'b0;
		irq_pin_one_sense = 1'b0;
		irq_pin_two_sense = 1'b0;
		do_reset();
		rd(8'h40, 8'hA8);
		rd(8'h41, 8'h01);
		rd(8'h45, 8'h80);
		rd(8'h46, 8'h00);
		rd(8'h47, 8'h00);
		rd(8'h48, 8'h02);
		rd(8'h49, 8'h10);
		rd(8'h53, 8'h00);
		rd(8'h50, 8'h00);
		chk(full_scale_mg, 15'h1770);
		chk(watermark, 1);
		tick();
		repeat (3) @(posedge sys_clk);
		chk(fill_level, 0);
		$display("reset values done");
		for (int f = 8; f <= 10; f++) begin
			for (int r = 5; r <= 12; r++) begin
				v = {f[3:0], r[3:0]};
				wr(8'h40, v);
				rd(8'h40, v);
				chk({filter_sel, rate_sel, cfg_invalid}, {v, 1'b0});
			end
		end
		wr(8'h40, 8'h58);
		rd(8'h40, 8'h58);
		chk(cfg_invalid, 1);
		wr(8'h40, 8'hA8);
		rd(8'h40, 8'hA8);
		chk(cfg_invalid, 0);
		wr(8'h40, 8'hA3);
		rd(8'h40, 8'hA3);
		chk(cfg_invalid, 1);
		for (int s = 0; s < 4; s++) begin
			wr(8'h41, {6'h3F, s[1:0]});
			rd(8'h41, {6'h00, s[1:0]});
			chk(full_scale_mg, 32'd3000 << s);
			chk(span_sel, s[1:0]);
		end
		wr(8'h45, 8'h7F);
		rd(8'h45, 8'h80);
		$display("config fields done");
		wr(8'h46, 8'h0E);
		wr(8'h47, 8'hE0);
		rd(8'h47, 8'h00);
		wr(8'h49, 8'h60);
		rd(8'h49, 8'h50);
		wr(8'h48, 8'h01);
		rd(8'h48, 8'h03);
		tick();
		wait_push(2'h1, 14'd7);
		chk(watermark, 0);
		tick();
		wait_push(2'h1, 14'd14);
		chk(watermark, 1);
		read_frame(14'd7);
		chk(watermark, 0);
		$display("threshold done");
		for (int i = 0; i < 8; i++) begin
			v = {4'h1, i[2:0], 1'b0};
			wr(8'h53, v);
			rd(8'h53, v);
			repeat (2) begin
				rnd = $random(seed);
				irq_one_src <= rnd[0];
				@(posedge sys_clk);
				o_x = v[1] ? rnd[0] : !rnd[0];
				chk(irq_pin_one.o, o_x);
				chk(irq_pin_one.oe, v[3] & (!v[2] | !o_x));
			end
		end
		$display("pin drive done");
		i_host.arm_pin1();
		irq_pin_one_sense <= 1'b1;
		wait_push(2'h2, 14'd9);
		@(posedge sys_clk);
		pin2_input_en <= 1'b1;
		wr(8'h49, 8'h04);
		irq_pin_two_sense <= 1'b1;
		wait_push(2'h2, 14'd11);
		$display("pin events done");
		@(posedge sys_clk);
		do_reset();
		wr(8'h49, 8'h40);
		wr(8'h48, 8'h01);
		repeat (150) tick();
		repeat (3) @(posedge sys_clk);
		chk(fill_level, 14'd1022);
		chk(drops, 4);
		wr(8'h48, 8'h00);
		tick();
		repeat (3) @(posedge sys_clk);
		chk(evicts, 1);
		chk(fill_level, 14'd1022);
		read_frame(14'd1015);
		repeat (4) @(posedge sys_clk);
		chk(exp_q.size(), 0);
		$display("full buffer done");
		conclude();
	end
endmodule : accel_config_fifo_setup_regs_bench
